// [src/tae_pkg.sv]
// constants, types and register map of the trace and address-error exception unit
// assumes a 24-bit physical address space and a classic Wishbone register port
package tae_pkg;
  localparam int ADDR_W = 24;
  localparam int NUM_MASTERS = 3;
  localparam int MST_CPU = 0;
  localparam int MST_DTC = 1;
  localparam int MST_DMA = 2;
  localparam int NUM_EXT_REQ = 16;

  // register byte offsets
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_EXR = 5'h04;
  localparam logic [4:0] REG_CCR = 5'h08;
  localparam logic [4:0] REG_VBR = 5'h0c;
  localparam logic [4:0] REG_STATUS = 5'h10;
  localparam logic [4:0] REG_DMATE = 5'h14;
  localparam logic [4:0] REG_SAVED = 5'h18;
  localparam logic [4:0] REG_ERRADDR = 5'h1c;

  // field positions
  localparam int CTRL_MODE2_BIT = 0;
  localparam int CTRL_SINGLE_BIT = 1;
  localparam int EXR_TRACE_BIT = 7;
  localparam int CCR_IMASK_BIT = 7;
  localparam int CCR_UI_BIT = 6;
  localparam int ST_TRACE_BIT = 0;
  localparam int ST_PEND_BIT = 1;
  localparam int ST_DTCERR_BIT = 2;
  localparam int ST_DMAERR_BIT = 3;
  localparam int ST_BUSY_BIT = 4;

  // reset values
  localparam logic [7:0] EXR_RESET = 8'h07;
  localparam logic [7:0] CCR_RESET = 8'h80;
  localparam logic [31:0] VBR_RESET = 32'h0000_0000;
  localparam logic [2:0] PRIO_MAX = 3'h7;

  // vector numbers and table layout
  localparam logic [7:0] VEC_TRACE = 8'h05;
  localparam logic [7:0] VEC_NMI = 8'h07;
  localparam logic [7:0] VEC_CPU_AERR = 8'h0c;
  localparam logic [7:0] VEC_DMA_AERR = 8'h0d;
  localparam logic [7:0] VEC_EXT_BASE = 8'h40;
  localparam int VEC_SHIFT = 2;

  // reserved window exempt from the reserved-area error (odd fetches and single transfers there still err)
  localparam logic [ADDR_W-1:0] RSV_OK_LO = 24'hff8000;
  localparam logic [ADDR_W-1:0] RSV_OK_HI = 24'hff8fff;

  typedef enum logic [1:0] {ACC_FETCH, ACC_STACK, ACC_DATA, ACC_SINGLE} tae_acc_kind_t;
  typedef enum logic [1:0] {EXC_TRACE, EXC_CPU_AERR, EXC_DMA_AERR} tae_exc_kind_t;
  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_SAVE, ST_VEC} tae_state_t;

  typedef struct packed {
    logic valid;
    tae_acc_kind_t kind;
    logic [ADDR_W-1:0] addr;
  } tae_access_t;

  typedef struct packed {
    logic [31:0] pc;
    logic [7:0] condition_code_reg;
    logic [7:0] extended_control_reg;
    logic undef;
  } tae_save_t;
endpackage

// [src/tae_addr_check.sv]
// address-error classifier for one bus master
// assumes the access descriptor is valid for one cycle per bus cycle start
`timescale 1ns/1ps
`default_nettype none
module tae_addr_check
  import tae_pkg::*;
#(
  parameter logic [ADDR_W-1:0] EXT_LO = 24'h200000,
  parameter logic [ADDR_W-1:0] EXT_HI = 24'hfeffff,
  parameter logic [ADDR_W-1:0] RSV_LO = 24'hff0000,
  parameter logic [ADDR_W-1:0] RSV_HI = 24'hffbfff,
  parameter logic [ADDR_W-1:0] PER_LO = 24'hffc000,
  parameter logic [ADDR_W-1:0] PER_HI = 24'hffffff
) (
  // access under test
  input wire tae_access_t acc,
  input wire logic singleChip,
  // result
  output logic err
);
  wire logic odd = acc.addr[0];
  wire logic inExt = (acc.addr >= EXT_LO) && (acc.addr <= EXT_HI);
  wire logic inRsv = (acc.addr >= RSV_LO) && (acc.addr <= RSV_HI);
  wire logic inRsvOk = (acc.addr >= RSV_OK_LO) && (acc.addr <= RSV_OK_HI);
  wire logic inPer = (acc.addr >= PER_LO) && (acc.addr <= PER_HI);
  wire logic badArea = (inExt && singleChip) || (inRsv && !inRsvOk);
  wire logic fetchErr = odd || inPer || badArea;
  wire logic stackErr = odd;
  wire logic dataErr = badArea; // odd word data is fine
  wire logic singleErr = !inExt;

  assign err = acc.valid && ((acc.kind == ACC_FETCH && fetchErr) ||
                             (acc.kind == ACC_STACK && stackErr) ||
                             (acc.kind == ACC_DATA && dataErr) ||
                             (acc.kind == ACC_SINGLE && singleErr));
endmodule
`default_nettype wire

// [src/tae_exc_unit.sv]
// trace and address-error exception unit with a Wishbone register port
// assumes the pipeline reports instruction completion and bus-cycle end on core_clk
`timescale 1ns/1ps
`default_nettype none
module tae_exc_unit
  import tae_pkg::*;
#(
  parameter int DMA_CH = 4
) (
  // clock, reset, enable
  input wire logic core_clk,
  input wire logic reset,
  input wire logic ce,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [4:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // bus masters and pipeline
  input wire tae_access_t access [NUM_MASTERS],
  input wire logic busCycleEnd,
  input wire logic instrDone,
  input wire logic [31:0] pcIn,
  input wire logic [31:0] spIn,
  // exception entry handshakes
  output logic excActive,
  output logic saveValid,
  input wire logic saveReady,
  output tae_save_t saveData,
  output logic vecValid,
  input wire logic vecReady,
  output logic [31:0] vecAddr,
  output logic [7:0] excVector,
  // interrupt sources
  input wire logic nmiPin,
  input wire logic [NUM_EXT_REQ-1:0] extReqPin,
  input wire logic periphReq,
  input wire logic [7:0] periphVector,
  output logic intRequest,
  output logic [7:0] intVector,
  // status toward dma and transfer controller
  output logic traceMode,
  output logic dtcErr,
  output logic dmaErrFlag,
  output logic [DMA_CH-1:0] dmaTransferEnable
);
  logic [1:0] ctrl;
  logic [7:0] extReg;
  logic [7:0] ccReg;
  logic [31:0] vector_base_reg;
  logic [31:0] savedFlags;
  logic [ADDR_W-1:0] errAddr;
  logic ackQ;
  logic [31:0] rdData;
  tae_state_t state;
  tae_exc_kind_t kind;
  logic pendErr;
  logic pendDma;
  logic busSeen;
  logic nmiS1;
  logic nmiS2;
  logic [NUM_EXT_REQ-1:0] extS1;
  logic [NUM_EXT_REQ-1:0] extS2;
  logic [NUM_MASTERS-1:0] mstErr;

  // address checks, one per bus master
  genvar gi;
  generate
    for (gi = 0; gi < NUM_MASTERS; gi++) begin : g_chk
      tae_addr_check u_chk (
        .acc(access[gi]),
        .singleChip(ctrl[CTRL_SINGLE_BIT]),
        .err(mstErr[gi])
      );
    end
  endgenerate

  // mode and trace decode
  // in mode 0 the trace bit is ignored, so a stale bit cannot trap
  wire logic mode2 = ctrl[CTRL_MODE2_BIT];
  assign traceMode = mode2 && extReg[EXR_TRACE_BIT];

  // error acceptance
  wire logic cpuErr = mstErr[MST_CPU];
  wire logic dmaErr = mstErr[MST_DTC] || mstErr[MST_DMA];
  wire logic anyErr = cpuErr || dmaErr;
  wire logic aerrKind = (kind == EXC_CPU_AERR) || (kind == EXC_DMA_AERR);
  wire logic aerrBusy = pendErr || (state == ST_WAIT) ||
                        ((state == ST_SAVE || state == ST_VEC) && aerrKind);
  // refusing errors while one is pending or entered stops stacking faults from looping
  wire logic acceptErr = anyErr && !aerrBusy;
  wire logic [ADDR_W-1:0] errSrcAddr = cpuErr ? access[MST_CPU].addr :
                                       mstErr[MST_DTC] ? access[MST_DTC].addr :
                                       access[MST_DMA].addr;

  // sequencing conditions
  wire logic busEnded = busSeen || busCycleEnd;
  wire logic aerrGo = (state == ST_WAIT) && busEnded && instrDone;
  // trace waits behind any pending address error
  wire logic traceGo = (state == ST_IDLE) && !pendErr && traceMode && instrDone;
  wire logic saveDone = (state == ST_SAVE) && saveReady;
  wire logic vecDone = (state == ST_VEC) && vecReady;
  wire tae_exc_kind_t goKind = aerrGo ? (pendDma ? EXC_DMA_AERR : EXC_CPU_AERR) : EXC_TRACE;
  wire logic [7:0] goVector = (goKind == EXC_TRACE) ? VEC_TRACE :
                              (goKind == EXC_DMA_AERR) ? VEC_DMA_AERR : VEC_CPU_AERR;
  wire logic [31:0] goOffset = {22'h000000, goVector, 2'h0};
  // cpu address errors bypass the base register so a bad base cannot recurse
  wire logic [31:0] goVecAddr = (goKind == EXC_CPU_AERR) ? goOffset : vector_base_reg + goOffset;

  // mask updates applied once the stacking is done
  wire logic [7:0] entryCcr = ccReg | (8'h01 << CCR_IMASK_BIT);
  wire logic [7:0] traceExr = extReg & ~(8'h01 << EXR_TRACE_BIT);
  wire logic [7:0] aerrExr = {traceExr[7:3], PRIO_MAX};
  // mode 0 leaves the extended register alone
  wire logic [7:0] entryExr = !mode2 ? extReg : (aerrKind ? aerrExr : traceExr);

  assign excActive = state != ST_IDLE;
  assign saveValid = state == ST_SAVE;
  assign vecValid = state == ST_VEC;

  // wishbone decode
  wire logic wbReq = wb_cyc_i && wb_stb_i;
  // writes land on the ack edge, while address and data are still held
  wire logic wbWrite = wbReq && wb_we_i && ackQ;
  wire logic wrCtrl = wbWrite && wb_adr_i == REG_CTRL && wb_sel_i[0];
  wire logic wrExr = wbWrite && wb_adr_i == REG_EXR && wb_sel_i[0];
  wire logic wrCcr = wbWrite && wb_adr_i == REG_CCR && wb_sel_i[0];
  wire logic wrVbr = wbWrite && wb_adr_i == REG_VBR;
  wire logic wrStatus = wbWrite && wb_adr_i == REG_STATUS && wb_sel_i[0];
  wire logic wrDmaTe = wbWrite && wb_adr_i == REG_DMATE && wb_sel_i[0];
  wire logic [31:0] selMask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                               {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  // status word built from the package field positions
  logic [31:0] statusWord;
  always_comb begin
    statusWord = 32'h0000_0000;
    statusWord[ST_TRACE_BIT] = traceMode;
    statusWord[ST_PEND_BIT] = pendErr;
    statusWord[ST_DTCERR_BIT] = dtcErr;
    statusWord[ST_DMAERR_BIT] = dmaErrFlag;
    statusWord[ST_BUSY_BIT] = excActive;
  end
  // unmapped offsets read zero
  wire logic [31:0] readMux = (wb_adr_i == REG_CTRL) ? {30'h00000000, ctrl} :
                              (wb_adr_i == REG_EXR) ? {24'h000000, extReg} :
                              (wb_adr_i == REG_CCR) ? {24'h000000, ccReg} :
                              (wb_adr_i == REG_VBR) ? vector_base_reg :
                              (wb_adr_i == REG_STATUS) ? statusWord :
                              (wb_adr_i == REG_DMATE) ? 32'(dmaTransferEnable) :
                              (wb_adr_i == REG_SAVED) ? savedFlags :
                              (wb_adr_i == REG_ERRADDR) ? {8'h00, errAddr} : 32'h0000_0000;

  assign wb_ack_o = ackQ;
  assign wb_dat_o = rdData;

  // maskable interrupts ride on the flag mask; nmi always wins
  wire logic extAny = |extS2;
  logic [7:0] extVec;
  always_comb begin
    extVec = VEC_EXT_BASE;
    for (int i = NUM_EXT_REQ - 1; i >= 0; i--) begin
      if (extS2[i]) begin
        extVec = VEC_EXT_BASE + 8'(i);
      end
    end
  end
  wire logic maskOpen = !ccReg[CCR_IMASK_BIT];
  // every entry, trace included, sets the CCR mask bit, so only nmi gets through in the handler
  wire logic intAny = nmiS2 || (maskOpen && (extAny || periphReq));
  wire logic [7:0] next_intVector = nmiS2 ? VEC_NMI : (extAny ? extVec : periphVector);

  // pin synchronisers
  always_ff @(posedge core_clk) begin
    if (reset) begin
      nmiS1 <= 1'b0;
      nmiS2 <= 1'b0;
      extS1 <= '0;
      extS2 <= '0;
    end else if (ce) begin
      nmiS1 <= nmiPin;
      nmiS2 <= nmiS1;
      extS1 <= extReqPin;
      extS2 <= extS1;
    end
  end

  // interrupt request toward the pipeline
  // held off while an error waits so the error entry goes first
  always_ff @(posedge core_clk) begin
    if (reset) begin
      intRequest <= 1'b0;
      intVector <= 8'h00;
    end else if (ce) begin
      intRequest <= intAny && (state == ST_IDLE) && !pendErr;
      intVector <= next_intVector;
    end
  end

  // wishbone handshake and read data
  // ack lasts one cycle, so a request left up is answered every other cycle
  always_ff @(posedge core_clk) begin
    if (reset) begin
      ackQ <= 1'b0;
      rdData <= 32'h0000_0000;
    end else if (ce) begin
      ackQ <= wbReq && !ackQ;
      if (wbReq && !ackQ) begin
        rdData <= readMux;
      end
    end
  end

  // exception sequencer
  always_ff @(posedge core_clk) begin
    if (reset) begin
      state <= ST_IDLE;
      kind <= EXC_TRACE;
      pendErr <= 1'b0;
      pendDma <= 1'b0;
      busSeen <= 1'b0;
      saveData <= '0;
      vecAddr <= 32'h0000_0000;
      excVector <= 8'h00;
      errAddr <= '0;
    end else if (ce) begin
      // a bus end seen with or after the error still counts once the instruction ends
      if (acceptErr) begin
        pendErr <= 1'b1;
        pendDma <= !cpuErr;
        errAddr <= errSrcAddr;
        busSeen <= busCycleEnd;
      end else if (busCycleEnd && (pendErr || state == ST_WAIT)) begin
        busSeen <= 1'b1;
      end
      case (state)
        ST_IDLE: begin
          if (pendErr) begin
            state <= ST_WAIT;
            pendErr <= 1'b0;
          end else if (traceGo) begin
            state <= ST_SAVE;
            kind <= goKind;
            excVector <= goVector;
            vecAddr <= goVecAddr;
            saveData <= '{pc: pcIn, condition_code_reg: ccReg, extended_control_reg: extReg, undef: 1'b0};
          end
        end
        ST_WAIT: begin
          // frame captured on the leaving edge so pc and sp belong to the finished instruction
          if (aerrGo) begin
            state <= ST_SAVE;
            kind <= goKind;
            busSeen <= 1'b0;
            excVector <= goVector;
            vecAddr <= goVecAddr;
            saveData <= '{pc: pcIn, condition_code_reg: ccReg, extended_control_reg: extReg, undef: spIn[0]};
          end
        end
        ST_SAVE: begin
          if (saveDone) begin
            state <= ST_VEC;
          end
        end
        ST_VEC: begin
          if (vecDone) begin
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // control and flag registers; hardware updates win over software writes
  always_ff @(posedge core_clk) begin
    if (reset) begin
      ctrl <= 2'h0;
      extReg <= EXR_RESET;
      ccReg <= CCR_RESET;
      vector_base_reg <= VBR_RESET;
      savedFlags <= 32'h0000_0000;
    end else if (ce) begin
      if (wrCtrl) begin
        ctrl <= wb_dat_i[1:0];
      end
      if (wrVbr) begin
        vector_base_reg <= (vector_base_reg & ~selMask) | (wb_dat_i & selMask);
      end
      // masks change only once stacking is done, so the frame keeps the old values
      if (saveDone) begin
        ccReg <= entryCcr;
        extReg <= entryExr;
        savedFlags <= {16'h0000, saveData.condition_code_reg, saveData.extended_control_reg}; // stacked trace bit kept
      end else begin
        if (wrExr) begin
          extReg <= wb_dat_i[7:0];
        end
        if (wrCcr) begin
          ccReg <= wb_dat_i[7:0];
        end
      end
    end
  end

  // per-channel transfer enables; an accepted address error drops every channel
  wire logic [DMA_CH-1:0] next_dmaTransferEnable;
  genvar ci;
  generate
    for (ci = 0; ci < DMA_CH; ci++) begin : g_dte
      assign next_dmaTransferEnable[ci] = acceptErr ? 1'b0 :
                                          wrDmaTe ? wb_dat_i[ci] : dmaTransferEnable[ci];
    end
  endgenerate

  // halting of the transfer controller and dma on address error
  always_ff @(posedge core_clk) begin
    if (reset) begin
      dtcErr <= 1'b0;
      dmaErrFlag <= 1'b0;
      dmaTransferEnable <= '0;
    end else if (ce) begin
      // set beats a same-cycle write-one-to-clear so an error is never lost
      if (acceptErr) begin
        dtcErr <= 1'b1;
        dmaErrFlag <= 1'b1;
      end else begin
        if (wrStatus && wb_dat_i[ST_DTCERR_BIT]) begin
          dtcErr <= 1'b0;
        end
        if (wrStatus && wb_dat_i[ST_DMAERR_BIT]) begin
          dmaErrFlag <= 1'b0;
        end
      end
      dmaTransferEnable <= next_dmaTransferEnable;
    end
  end
endmodule
`default_nettype wire

// [dv/tae_exc_unit_sva.sv]
// checker for the trace and address-error exception unit
// assumes it is bound to tae_exc_unit and sees only its ports
`timescale 1ns/1ps
`default_nettype none
module tae_exc_unit_sva
  import tae_pkg::*;
#(
  parameter int DMA_CH = 4
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // masters and pipeline
  input wire tae_access_t access [NUM_MASTERS],
  input wire logic instrDone,
  input wire logic saveReady,
  input wire logic vecReady,
  // entry sequence
  input wire logic excActive,
  input wire logic saveValid,
  input wire logic vecValid,
  input wire logic [31:0] vecAddr,
  input wire logic [7:0] excVector,
  // error status
  input wire logic dtcErr,
  input wire logic dmaErrFlag,
  input wire logic [DMA_CH-1:0] dmaTransferEnable
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  wire cpuOnly = access[0].valid && !access[1].valid && !access[2].valid;
  wire dmaOnly = access[2].valid && !access[0].valid && !access[1].valid;
  AST_HALT_DMA: assert property ($rose(dmaErrFlag) |-> dtcErr && dmaTransferEnable == '0)
    else $error("dma not halted on address error");
  AST_WORD_DATA: assert property (cpuOnly && access[0].kind == ACC_DATA &&
    access[0].addr < 24'h200000 && !dtcErr |=> !dtcErr) else $error("word data access erred");
  AST_ODD_FETCH: assert property (cpuOnly && access[0].kind == ACC_FETCH &&
    access[0].addr[0] && !excActive && !dtcErr |=> dtcErr && dmaErrFlag)
    else $error("odd fetch gave no error");
  AST_EXEMPT: assert property (dmaOnly && access[2].kind == ACC_DATA &&
    access[2].addr inside {[RSV_OK_LO:RSV_OK_HI]} && !dtcErr |=> !dtcErr)
    else $error("exempt window erred");
  AST_SINGLE: assert property (dmaOnly && access[2].kind == ACC_SINGLE &&
    access[2].addr < 24'h200000 && !excActive && !dtcErr |=> dtcErr)
    else $error("internal single transfer gave no error");
  AST_WAIT_DONE: assert property ($rose(saveValid) |-> $past(instrDone))
    else $error("entry began without instruction end");
  AST_SAVE_HOLD: assert property (saveValid && !saveReady |=> saveValid)
    else $error("frame offer withdrawn");
  AST_SAVE_VEC: assert property (saveValid && saveReady |=> vecValid && !saveValid)
    else $error("vector fetch did not follow stacking");
  AST_VEC_END: assert property (vecValid && vecReady |=> !vecValid && !excActive)
    else $error("entry did not end after vector fetch");
  AST_CPU_VEC: assert property (vecValid && excVector == VEC_CPU_AERR |-> vecAddr == 32'h30)
    else $error("cpu error vector used base register");
  CV_TRACE: cover property (vecValid && excVector == VEC_TRACE);
  CV_CPU: cover property (vecValid && excVector == VEC_CPU_AERR);
  CV_DMA: cover property (vecValid && excVector == VEC_DMA_AERR);
endmodule
`default_nettype wire

// [dv/tae_pipe_model.sv]
// stand-in for the pipeline that takes stack frames and vector fetches
// assumes saveValid and vecValid stay up until answered
`timescale 1ns/1ps
`default_nettype none
module tae_pipe_model (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // handshakes
  input wire logic saveValid,
  input wire logic vecValid,
  input wire logic [1:0] delay,
  output logic saveReady,
  output logic vecReady
);
  logic [1:0] waitCnt;
  // answer after delay cycles with a one-cycle ready: frame first, then vector
  always_ff @(posedge core_clk) begin
    if (reset || saveReady || vecReady || !(saveValid || vecValid)) begin
      waitCnt <= 2'h0;
      saveReady <= 1'b0;
      vecReady <= 1'b0;
    end else if (waitCnt == delay) begin
      saveReady <= saveValid;
      vecReady <= vecValid;
    end else begin
      waitCnt <= waitCnt + 2'h1;
    end
  end
endmodule
`default_nettype wire

// [dv/tb_trace_and_address_error_exceptions.sv]
// testbench for the trace and address-error exception unit
// assumes a 250 MHz clock and a Wishbone master made of tasks
`timescale 1ns/1ps
`default_nettype none
module tb_trace_and_address_error_exceptions;
  import tae_pkg::*;
  logic core_clk = 1'b0, reset = 1'b1, hung = 1'b0;
  logic wbCyc = 0, wbStb = 0, wbWe = 0, wbAck, nmiPin = 0, busCycleEnd = 0, instrDone = 0;
  logic [4:0] wbAdr = 5'h00;
  logic [3:0] wbSel = 4'hf;
  logic [31:0] wbDatI = 32'h0, wbDatO, spIn = 32'h0, vecAddr;
  logic [7:0] excVector, intVector;
  logic [1:0] delay = 2'h0;
  logic [3:0] dmaTransferEnable;
  logic excActive, saveValid, saveReady, vecValid, vecReady, intRequest, traceMode, dtcErr, dmaErr;
  tae_save_t saveData;
  tae_access_t access [NUM_MASTERS] = '{default: '0};
  int miscompares = 0, checkCount = 0, cycles = 0;
  always #2 core_clk = ~core_clk;
  tae_exc_unit u_tae_exc_unit (.core_clk(core_clk), .reset(reset), .ce(1'b1),
    .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel),
    .wb_dat_i(wbDatI), .wb_dat_o(wbDatO), .wb_ack_o(wbAck), .access(access),
    .busCycleEnd(busCycleEnd), .instrDone(instrDone), .pcIn(32'h0000_1000), .spIn(spIn),
    .excActive(excActive), .saveValid(saveValid), .saveReady(saveReady), .saveData(saveData),
    .vecValid(vecValid), .vecReady(vecReady), .vecAddr(vecAddr), .excVector(excVector),
    .nmiPin(nmiPin), .extReqPin(16'h0000), .periphReq(1'b0), .periphVector(8'h00),
    .intRequest(intRequest), .intVector(intVector), .traceMode(traceMode), .dtcErr(dtcErr),
    .dmaErrFlag(dmaErr), .dmaTransferEnable(dmaTransferEnable));
  tae_pipe_model u_tae_pipe_model (.core_clk(core_clk), .reset(reset), .saveValid(saveValid),
    .vecValid(vecValid), .delay(delay), .saveReady(saveReady), .vecReady(vecReady));
  task automatic conclude();
    if (miscompares == 0 && checkCount > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cycles++;
    if (cycles > 20000) begin
      miscompares++;
      conclude();
    end else if (hung) conclude();
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checkCount++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tick(inout int n);
    @(posedge core_clk);
    n++;
    if (n == 60) begin
      miscompares++;
      hung = 1'b1;
    end
  endtask
  task automatic wbXfer(input logic we, input logic [4:0] adr, input logic [31:0] dat,
      output logic [31:0] rd);
    int n;
    n = 0;
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= adr;
    wbDatI <= dat;
    do tick(n); while (wbAck !== 1'b1 && n < 60);
    rd = wbDatO;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic wr(input logic [4:0] adr, input logic [31:0] dat);
    logic [31:0] d;
    wbXfer(1'b1, adr, dat, d);
  endtask
  task automatic rdChk(input string nm, input logic [4:0] adr, input logic [31:0] exp);
    logic [31:0] d;
    wbXfer(1'b0, adr, 32'h0, d);
    chk(nm, exp, d);
  endtask
  task automatic endInstr();
    busCycleEnd <= 1'b1;
    instrDone <= 1'b1;
    @(posedge core_clk);
    busCycleEnd <= 1'b0;
    instrDone <= 1'b0;
  endtask
  // follows one entry through stacking and vector fetch
  task automatic runEntry(input logic [7:0] vec, input logic [31:0] adr, input logic undef);
    int n;
    n = 0;
    while (saveValid !== 1'b1 && n < 60) tick(n);
    chk("undef", {31'h0, undef}, {31'h0, saveData.undef});
    chk("pc", 32'h0000_1000, saveData.pc);
    while (vecValid !== 1'b1 && n < 60) tick(n);
    chk("vector", {24'h0, vec}, {24'h0, excVector});
    chk("vecAddr", adr, vecAddr);
    while (excActive !== 1'b0 && n < 60) tick(n);
  endtask
  task automatic acase(input int m, input tae_acc_kind_t k, input logic [23:0] a,
      input logic sc, input logic md, input logic err);
    wr(REG_CTRL, {30'h0, sc, md});
    wr(REG_EXR, 32'h02);
    wr(REG_CCR, 32'h40);
    wr(REG_STATUS, 32'h0c);
    wr(REG_DMATE, 32'h0f);
    spIn <= {8'h0, a};
    delay <= a[1:0];
    access[m] <= tae_access_t'{valid: 1'b1, kind: k, addr: a};
    @(posedge core_clk);
    access[m].valid <= 1'b0;
    @(posedge core_clk);
    chk("dtcErr", {31'h0, err}, {31'h0, dtcErr});
    chk("dmaErr", {31'h0, err}, {31'h0, dmaErr});
    chk("enables", err ? 32'h0 : 32'hf, {28'h0, dmaTransferEnable});
    if (err) begin
      access[0] <= tae_access_t'{valid: 1'b1, kind: ACC_FETCH, addr: 24'h000003};
      repeat (3) @(posedge core_clk);
      access[0].valid <= 1'b0;
      chk("saveValid", 32'h0, {31'h0, saveValid});
      instrDone <= 1'b1;
      @(posedge core_clk);
      instrDone <= 1'b0;
      @(posedge core_clk);
      chk("saveValid", 32'h0, {31'h0, saveValid});
      endInstr();
      runEntry(m == 0 ? VEC_CPU_AERR : VEC_DMA_AERR, m == 0 ? 32'h30 : 32'h1034, a[0]);
      rdChk("ccr", REG_CCR, 32'h40 | 32'h80);
      rdChk("exr", REG_EXR, md ? 32'h07 : 32'h02);
      rdChk("errAddr", REG_ERRADDR, {8'h0, a});
      if (!a[0]) rdChk("saved", REG_SAVED, 32'h4002);
      chk("excActive", 32'h0, {31'h0, excActive});
    end
  endtask
  initial begin
    int n;
    n = 0;
    repeat (6) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    rdChk("exr", REG_EXR, 32'h07);
    rdChk("ccr", REG_CCR, 32'h80);
    rdChk("ctrl", REG_CTRL, 32'h0);
    rdChk("unmapped", 5'h02, 32'h0);
    wr(REG_EXR, 32'h83);
    endInstr();
    repeat (3) @(posedge core_clk);
    chk("mode0 trace", 32'h0, {30'h0, excActive, traceMode});
    wr(REG_EXR, 32'h03);
    wr(REG_CTRL, 32'h1);
    wr(REG_VBR, 32'h1000);
    wr(REG_CCR, 32'h40);
    wr(REG_EXR, 32'h83);
    chk("traceMode", 32'h1, {31'h0, traceMode});
    delay <= 2'h3;
    endInstr();
    runEntry(VEC_TRACE, 32'h1014, 1'b0);
    rdChk("ccr", REG_CCR, 32'hc0);
    rdChk("exr", REG_EXR, 32'h03);
    rdChk("saved", REG_SAVED, 32'h4083);
    chk("traceMode", 32'h0, {31'h0, traceMode});
    wr(REG_EXR, 32'h83);
    endInstr();
    runEntry(VEC_TRACE, 32'h1014, 1'b0);
    nmiPin <= 1'b1;
    while (intRequest !== 1'b1 && n < 60) tick(n);
    chk("intRequest", 32'h1, {31'h0, intRequest});
    chk("intVector", {24'h0, VEC_NMI}, {24'h0, intVector});
    nmiPin <= 1'b0;
    repeat (6) @(posedge core_clk);
    acase(0, ACC_FETCH, 24'h000100, 1, 1, 0);
    acase(0, ACC_FETCH, 24'h001001, 1, 1, 1);
    acase(0, ACC_FETCH, 24'hffc000, 0, 1, 1);
    acase(0, ACC_FETCH, 24'h300000, 1, 0, 1);
    acase(0, ACC_FETCH, 24'h300000, 0, 1, 0);
    acase(0, ACC_FETCH, 24'hff1000, 0, 1, 1);
    acase(0, ACC_STACK, 24'h000101, 0, 1, 1);
    acase(0, ACC_STACK, 24'h000100, 0, 1, 0);
    acase(0, ACC_DATA, 24'h000201, 0, 1, 0);
    acase(1, ACC_DATA, 24'h000101, 0, 1, 0);
    acase(2, ACC_DATA, 24'hff8010, 0, 1, 0);
    acase(1, ACC_DATA, 24'hff0100, 0, 1, 1);
    acase(2, ACC_DATA, 24'h400000, 1, 1, 1);
    acase(2, ACC_SINGLE, 24'h400000, 0, 1, 0);
    acase(2, ACC_SINGLE, 24'h000200, 0, 1, 1);
    conclude();
  end
endmodule
bind tae_exc_unit tae_exc_unit_sva #(.DMA_CH(DMA_CH)) u_tae_exc_unit_sva (.core_clk(core_clk),
  .reset(reset), .access(access), .instrDone(instrDone), .saveReady(saveReady),
  .vecReady(vecReady), .excActive(excActive), .saveValid(saveValid), .vecValid(vecValid),
  .vecAddr(vecAddr), .excVector(excVector), .dtcErr(dtcErr), .dmaErrFlag(dmaErrFlag),
  .dmaTransferEnable(dmaTransferEnable));
`default_nettype wire
